// ### emb_map.svh
`ifndef EMB_MAP_SVH
`define EMB_MAP_SVH
// Clock rate, handshake timing and extended-timing wait count
`define EMB_CLK_MHZ         100
`define EMB_DAVF_RDY_NS     70
`define EMB_DAVR_RDY_NS     40
`define EMB_DAVF_RDY_CYC    ((`EMB_DAVF_RDY_NS * `EMB_CLK_MHZ) / 1000)
`define EMB_DAVR_RDY_CYC    ((`EMB_DAVR_RDY_NS * `EMB_CLK_MHZ) / 1000)
`define EMB_EXT_WAIT        2
// Nibble mode field encodings
`define EMB_NIB_IN          2'h0
`define EMB_NIB_OUT         2'h1
`define EMB_NIB_ADDR        2'h2
// Register offsets
`define EMB_REG_MODE        4'h0
`define EMB_REG_DOUT        4'h1
`define EMB_REG_DIN         4'h2
`define EMB_REG_CTRL        4'h3
`define EMB_REG_STAT        4'h4
// Mode register fields
`define EMB_MODE_LO_POS     0
`define EMB_MODE_HI_POS     2
// Control register bits
`define EMB_CTRL_EXT_BIT    0
`define EMB_CTRL_TRI_BIT    1
`define EMB_CTRL_HS_BIT     2
// Reset values
`define EMB_MODE_RST_ROMLESS 4'ha
`define EMB_MODE_RST_ROM     4'h0
`endif

// ### emb_pkg.sv
package emb_pkg;
	typedef enum logic [2:0] {
		BUS_IDLE  = 3'b000,
		BUS_ADDR  = 3'b001,
		BUS_GAP   = 3'b011,
		BUS_DATA  = 3'b010,
		BUS_WAIT  = 3'b110,
		BUS_END   = 3'b111
	} emb_bus_t;
	typedef enum logic [1:0] {
		HS_IDLE = 2'b00,
		HS_BUSY = 2'b01,
		HS_DONE = 2'b11
	} emb_hs_t;
endpackage

// ### emb_port.sv
`timescale 1ns/100ps
`include "emb_map.svh"
// How it works
// - Read/write line high during reads, low during writes.
// - Address strobe pulses low once at the start of each machine cycle.
// - Address is valid when the address strobe rises; memory captures it then.
// - Software tri-state floats both strobes, read/write line and high-port address nibbles; it blocks new transfers but does not gate the multiplexed bus.
// - Data strobe goes low once per external transfer and never otherwise.
// - Write data is on the bus no later than the data strobe falls.
// - High port carries A11-A8 on low nibble or A15-A8 on both.
// - With 12-bit addressing the upper nibble may stay general I/O.
// - Mode register chooses I/O or address use for each nibble.
// - Romless reset: high port is A15-A8 and extended timing on.
// - With internal memory, whole high port is input after reset.
// - Handshake enabled: two control pins act as data-valid and ready.
// - Upper nibble direction sets handshake direction; lower must match.
// - Input mode: ready falls after data-valid falls, data latched.
// - Input mode: ready rises again after data-valid returns high.
// - Output mode: byte driven at least one clock before data-valid falls.
// - Output mode: receiver drops ready, device then raises data-valid.
// - Input pins of the high port are sampled into a register every clock.
// - Extended timing adds two clock periods to each access.
// - Data strobe asserts only after address strobe has returned high.
module emb_port #(
	parameter int DAVF_CYC = `EMB_DAVF_RDY_CYC,
	parameter int DAVR_CYC = `EMB_DAVR_RDY_CYC
) (
	input  wire logic        clk,
	input  wire logic        rst_b,
	input  wire logic        romlessSelect,
	input  wire logic [3:0]  regAddr,
	input  wire logic [7:0]  regWdata,
	input  wire logic        regWr,
	input  wire logic        regRd,
	output logic      [7:0]  regRdata,
	input  wire logic        memReq,
	input  wire logic        memWrite,
	input  wire logic [15:0] memAddr,
	input  wire logic [7:0]  memWdata,
	output logic             memDone,
	output logic      [7:0]  memRdata,
	output logic             addrStrobe_n,
	output logic             addrStrobeOe,
	output logic             dataStrobe_n,
	output logic             dataStrobeOe,
	output logic             readNotWrite,
	output logic             readNotWriteOe,
	input  wire logic [7:0]  adIn,
	output logic      [7:0]  adOut,
	output logic      [7:0]  adOe,
	input  wire logic [7:0]  hiIn,
	output logic      [7:0]  hiOut,
	output logic      [7:0]  hiOe,
	input  wire logic        dataValidIn,
	input  wire logic        readyIn,
	output logic             dataValidOut,
	output logic             readyOut
);
	// ----------------------------------------------------------------
	// Registers
	// ----------------------------------------------------------------
	logic [3:0]  mode_r;
	logic [7:0]  dout_r;
	logic [7:0]  din_r;
	logic [2:0]  ctrl_r;
	logic [7:0]  hiHold_r;
	logic        hsFlag_r;
	logic        rstSeen_r;

	wire  [1:0]  loMode   = mode_r[`EMB_MODE_LO_POS +: 2];
	wire  [1:0]  hiMode   = mode_r[`EMB_MODE_HI_POS +: 2];
	wire         extTime  = ctrl_r[`EMB_CTRL_EXT_BIT];
	wire         triState = ctrl_r[`EMB_CTRL_TRI_BIT];
	wire         hsEn     = ctrl_r[`EMB_CTRL_HS_BIT];
	wire         hsOutDir = (hiMode == `EMB_NIB_OUT);
	wire         wrMode   = regWr && (regAddr == `EMB_REG_MODE);
	wire         wrDout   = regWr && (regAddr == `EMB_REG_DOUT);
	wire         wrCtrl   = regWr && (regAddr == `EMB_REG_CTRL);
	wire         rdDin    = regRd && (regAddr == `EMB_REG_DIN);
	logic        hsSet;

	function automatic logic nibOut(input logic [1:0] m);
		nibOut = (m != `EMB_NIB_IN);
	endfunction

	// Mode and control load reset values once the synchronous reset is seen
	always_ff @(posedge clk) begin
		if (!rst_b) begin
			rstSeen_r <= 1'b1;
			mode_r    <= `EMB_MODE_RST_ROM;
			ctrl_r    <= 3'h0;
		end else if (rstSeen_r) begin
			rstSeen_r <= 1'b0;
			mode_r    <= romlessSelect ? `EMB_MODE_RST_ROMLESS : `EMB_MODE_RST_ROM;
			ctrl_r    <= {2'b00, romlessSelect};
		end else begin
			if (wrMode) begin
				mode_r <= regWdata[3:0];
			end
			if (wrCtrl) begin
				ctrl_r <= regWdata[2:0];
			end
		end
	end

	always_ff @(posedge clk) begin
		if (!rst_b) begin
			dout_r <= 8'h00;
		end else if (wrDout) begin
			dout_r <= regWdata;
		end
	end

	// ----------------------------------------------------------------
	// Register read port
	// ----------------------------------------------------------------
	// Status: romless pin, handshake direction, completion flag, bus floated
	wire [7:0] statVal = {4'h0, romlessSelect, hsOutDir, hsFlag_r, triState};
	wire [7:0] rdMux = (regAddr == `EMB_REG_MODE) ? {4'h0, mode_r} :
	                   (regAddr == `EMB_REG_DOUT) ? dout_r :
	                   (regAddr == `EMB_REG_DIN)  ? din_r :
	                   (regAddr == `EMB_REG_CTRL) ? {5'h00, ctrl_r} :
	                   (regAddr == `EMB_REG_STAT) ? statVal : 8'h00;

	always_ff @(posedge clk) begin
		if (!rst_b) begin
			regRdata <= 8'h00;
		end else if (regRd) begin
			regRdata <= rdMux;
		end
	end

	// ----------------------------------------------------------------
	// External memory sequencer
	// ----------------------------------------------------------------
	emb_pkg::emb_bus_t bus_r;
	emb_pkg::emb_bus_t bus_nxt;
	logic [1:0]  wait_r;
	logic        isWr_r;
	logic [15:0] addr_r;
	logic [7:0]  wdat_r;

	always_comb begin
		bus_nxt = bus_r;
		case (bus_r)
			emb_pkg::BUS_IDLE: begin
				if (memReq && !triState) begin
					bus_nxt = emb_pkg::BUS_ADDR;
				end
			end
			emb_pkg::BUS_ADDR: begin
				bus_nxt = emb_pkg::BUS_GAP;
			end
			emb_pkg::BUS_GAP: begin
				bus_nxt = emb_pkg::BUS_DATA;
			end
			emb_pkg::BUS_DATA: begin
				bus_nxt = extTime ? emb_pkg::BUS_WAIT : emb_pkg::BUS_END;
			end
			emb_pkg::BUS_WAIT: begin
				if (wait_r == 2'd1) begin
					bus_nxt = emb_pkg::BUS_END;
				end
			end
			default: begin
				bus_nxt = emb_pkg::BUS_IDLE;
			end
		endcase
	end

	always_ff @(posedge clk) begin
		if (!rst_b) begin
			bus_r  <= emb_pkg::BUS_IDLE;
			wait_r <= 2'd0;
			isWr_r <= 1'b0;
			addr_r <= 16'h0000;
			wdat_r <= 8'h00;
		end else begin
			bus_r <= bus_nxt;
			if (bus_r == emb_pkg::BUS_IDLE && bus_nxt == emb_pkg::BUS_ADDR) begin
				isWr_r <= memWrite;
				addr_r <= memAddr;
				wdat_r <= memWdata;
			end
			if (bus_r == emb_pkg::BUS_DATA) begin
				wait_r <= 2'(`EMB_EXT_WAIT);
			end else if (wait_r != 2'd0) begin
				wait_r <= wait_r - 2'd1;
			end
		end
	end

	// Strobes and multiplexed bus come from flip-flops to stay glitch free
	always_ff @(posedge clk) begin
		if (!rst_b) begin
			addrStrobe_n <= 1'b1;
			dataStrobe_n <= 1'b1;
			readNotWrite <= 1'b1;
			adOut        <= 8'h00;
			adOe         <= 8'h00;
			memDone      <= 1'b0;
			memRdata     <= 8'h00;
		end else begin
			addrStrobe_n <= !(bus_nxt == emb_pkg::BUS_ADDR);
			dataStrobe_n <= !((bus_nxt == emb_pkg::BUS_DATA) || (bus_nxt == emb_pkg::BUS_WAIT));
			readNotWrite <= (bus_nxt == emb_pkg::BUS_IDLE) ? 1'b1 :
			                (bus_r == emb_pkg::BUS_IDLE) ? !memWrite : !isWr_r;
			if (bus_r == emb_pkg::BUS_IDLE && bus_nxt == emb_pkg::BUS_ADDR) begin
				adOut <= memAddr[7:0];
				adOe  <= 8'hff;
			end else if (bus_r == emb_pkg::BUS_GAP) begin
				// Address stays out through the gap so it still holds after the strobe rises
				adOut <= isWr_r ? wdat_r : 8'h00;
				adOe  <= isWr_r ? 8'hff : 8'h00;
			end else if (bus_nxt == emb_pkg::BUS_IDLE) begin
				adOe  <= 8'h00;
			end
			memDone <= (bus_r == emb_pkg::BUS_END);
			// Read data is taken on the edge at which the data strobe rises
			if (bus_nxt == emb_pkg::BUS_END && !isWr_r) begin
				memRdata <= adIn;
			end
		end
	end

	assign addrStrobeOe   = !triState;
	assign dataStrobeOe   = !triState;
	assign readNotWriteOe = !triState;

	// ----------------------------------------------------------------
	// High address port
	// ----------------------------------------------------------------
	wire [7:0] hiAddr = (bus_r == emb_pkg::BUS_IDLE) ? memAddr[15:8] : addr_r[15:8];
	wire       loAddr = (loMode == `EMB_NIB_ADDR);
	wire       upAddr = (hiMode == `EMB_NIB_ADDR);
	wire [3:0] loNib  = loAddr ? hiAddr[3:0] : dout_r[3:0];
	wire [3:0] upNib  = upAddr ? hiAddr[7:4] : dout_r[7:4];
	wire       addrTri = triState;

	assign hiOut = {upNib, loNib};
	assign hiOe  = {{4{nibOut(hiMode) && !(upAddr && addrTri)}},
	                {4{nibOut(loMode) && !(loAddr && addrTri)}}};

	// Inputs are sampled into a register every clock, driven or not
	always_ff @(posedge clk) begin
		if (!rst_b) begin
			hiHold_r <= 8'h00;
		end else begin
			hiHold_r <= hiIn;
		end
	end

	// ----------------------------------------------------------------
	// Byte handshake
	// ----------------------------------------------------------------
	emb_pkg::emb_hs_t hs_r;

	always_ff @(posedge clk) begin
		if (!rst_b) begin
			hs_r         <= emb_pkg::HS_IDLE;
			readyOut     <= 1'b1;
			dataValidOut <= 1'b1;
			din_r        <= 8'h00;
			hsSet        <= 1'b0;
		end else begin
			hsSet    <= 1'b0;
			if (!hsEn) begin
				hs_r         <= emb_pkg::HS_IDLE;
				readyOut     <= 1'b1;
				dataValidOut <= 1'b1;
			end else if (!hsOutDir) begin
				case (hs_r)
					emb_pkg::HS_IDLE: begin
						if (!dataValidIn && readyOut) begin
							din_r    <= hiHold_r;
							readyOut <= 1'b0;
							hsSet    <= 1'b1;
							hs_r     <= emb_pkg::HS_BUSY;
						end
					end
					emb_pkg::HS_BUSY: begin
						if (dataValidIn) begin
							readyOut <= 1'b1;
							hs_r     <= emb_pkg::HS_IDLE;
						end
					end
					default: begin
						hs_r <= emb_pkg::HS_IDLE;
					end
				endcase
			end else begin
				case (hs_r)
					emb_pkg::HS_IDLE: begin
						if (wrDout) begin
							hs_r <= emb_pkg::HS_BUSY;
						end
					end
					emb_pkg::HS_BUSY: begin
						if (readyIn) begin
							dataValidOut <= 1'b0;
							hs_r         <= emb_pkg::HS_DONE;
						end
					end
					default: begin
						if (!readyIn) begin
							dataValidOut <= 1'b1;
							hsSet        <= 1'b1;
							hs_r         <= emb_pkg::HS_IDLE;
						end
					end
				endcase
			end
		end
	end

	// Sticky completion flag: a new completion wins over the read clear
	always_ff @(posedge clk) begin
		if (!rst_b) begin
			hsFlag_r <= 1'b0;
		end else if (hsSet) begin
			hsFlag_r <= 1'b1;
		end else if (rdDin) begin
			hsFlag_r <= 1'b0;
		end
	end

	// ----------------------------------------------------------------
	// Assertions
	// ----------------------------------------------------------------
	AST_RW_READ: assert property (@(posedge clk) disable iff (!rst_b)
		(!dataStrobe_n && !isWr_r) |-> readNotWrite) else $error("Read/write low during read");
	AST_RW_WRITE: assert property (@(posedge clk) disable iff (!rst_b)
		(!dataStrobe_n && isWr_r) |-> !readNotWrite) else $error("Read/write high during write");
	AST_AS_ONE: assert property (@(posedge clk) disable iff (!rst_b)
		$fell(addrStrobe_n) |=> addrStrobe_n[*4]) else $error("Address strobe not single pulse");
	AST_ADDR_HOLD: assert property (@(posedge clk) disable iff (!rst_b)
		$rose(addrStrobe_n) |-> (adOe == 8'hff) && $stable(adOut)) else $error("Address not valid at strobe rise");
	AST_TRI: assert property (@(posedge clk) disable iff (!rst_b)
		triState |-> !addrStrobeOe && !dataStrobeOe && !readNotWriteOe) else $error("Bus not floated");
	AST_DS_AFTER_AS: assert property (@(posedge clk) disable iff (!rst_b)
		$fell(dataStrobe_n) |-> $past(addrStrobe_n) && $past(addrStrobe_n, 2) == 1'b0) else $error("Data strobe early");
	AST_DS_LEN: assert property (@(posedge clk) disable iff (!rst_b)
		($fell(dataStrobe_n) && extTime) |-> !dataStrobe_n[*3] ##1 dataStrobe_n) else $error("Extended data strobe width");
	AST_WDATA: assert property (@(posedge clk) disable iff (!rst_b)
		($fell(dataStrobe_n) && isWr_r) |-> adOe == 8'hff && adOut == wdat_r) else $error("Write data late");
	AST_IDLE: assert property (@(posedge clk) disable iff (!rst_b)
		(bus_r == emb_pkg::BUS_IDLE && !triState) |-> addrStrobe_n && dataStrobe_n) else $error("Strobe active idle");
	AST_DS_ONCE: assert property (@(posedge clk) disable iff (!rst_b)
		$rose(dataStrobe_n) |=> dataStrobe_n[*3]) else $error("Data strobe repeated");
	AST_DONE_ONE: assert property (@(posedge clk) disable iff (!rst_b)
		memDone |=> !memDone) else $error("Done longer than one cycle");
	AST_RDATA: assert property (@(posedge clk) disable iff (!rst_b)
		(memDone && !isWr_r) |-> memRdata == $past(adIn, 2)) else $error("Read data not captured");
	AST_HI_ADDR: assert property (@(posedge clk) disable iff (!rst_b)
		(!addrStrobe_n && loAddr) |-> hiOut[3:0] == addr_r[11:8] && (!upAddr || hiOut[7:4] == addr_r[15:12]))
		else $error("High address wrong");
	AST_RDY_RISE: assert property (@(posedge clk) disable iff (!rst_b)
		(hsEn && !hsOutDir && hs_r == emb_pkg::HS_BUSY && dataValidIn) |=> readyOut) else $error("Ready not raised");
	AST_DAV_SETUP: assert property (@(posedge clk) disable iff (!rst_b)
		$fell(dataValidOut) |-> $stable(hiOut) && hiOe[7:4] == 4'hf) else $error("Output byte not set up");
	AST_RDY_FALL: assert property (@(posedge clk) disable iff (!rst_b)
		(hsEn && !hsOutDir && readyOut && !dataValidIn && hs_r == emb_pkg::HS_IDLE) |=> !readyOut) else $error("Ready late");
	AST_DAV_RISE: assert property (@(posedge clk) disable iff (!rst_b)
		(hsEn && hsOutDir && hs_r == emb_pkg::HS_DONE && !readyIn) |=> dataValidOut) else $error("Data valid not raised");
	CV_READ: cover property (@(posedge clk) $fell(dataStrobe_n) && !isWr_r);
	CV_WRITE: cover property (@(posedge clk) $fell(dataStrobe_n) && isWr_r);
	CV_HS_IN: cover property (@(posedge clk) $rose(readyOut));
	CV_HS_OUT: cover property (@(posedge clk) $rose(dataValidOut));
	CV_EXT_READ: cover property (@(posedge clk) $fell(dataStrobe_n) && extTime && !isWr_r);
endmodule

// ### emb_mem_model.sv
`timescale 1ns/100ps
// --------------------------------
// External memory on the shared bus
// --------------------------------
module emb_mem_model (
	input  wire logic       clk,
	input  wire logic       addrStrobe_n,
	input  wire logic       dataStrobe_n,
	input  wire logic       readNotWrite,
	input  wire logic [7:0] adOut,
	input  wire logic [7:0] hiOut,
	output logic      [7:0] adIn
);
	logic [7:0]  mem [65536];
	logic [15:0] latAddr_r = 16'h0000;
	logic [7:0]  last_r    = 8'h00;
	logic [7:0]  rdVal;
	logic        drive;

	initial begin
		for (int i = 0; i < 65536; i++) begin
			mem[i] = i[7:0] ^ i[15:8];
		end
	end
	assign drive = !dataStrobe_n && readNotWrite;
	assign rdVal = mem[latAddr_r];
	// Released bus shows a pattern that flips every cycle
	assign adIn  = drive ? rdVal : ~last_r;
	always @(posedge clk) begin
		if (!addrStrobe_n) begin
			latAddr_r <= {hiOut, adOut};
		end
		last_r <= drive ? rdVal : ~last_r;
		if (!dataStrobe_n && !readNotWrite) begin
			mem[latAddr_r] <= adOut;
		end
	end
endmodule

// ### emb_testbench.sv
`timescale 1ns/100ps
`include "emb_map.svh"
module testbench;
	logic        clk = 1'b0, rst_b = 1'b0, romlessSelect = 1'b0;
	logic [3:0]  regAddr = 4'h0;
	logic [7:0]  regWdata = 8'h00, hiIn = 8'h00, rd;
	logic        regWr = 1'b0, regRd = 1'b0, memReq = 1'b0, memWrite = 1'b0;
	logic [15:0] memAddr = 16'h0000;
	logic [7:0]  memWdata = 8'h00, regRdata, memRdata, adIn, adOut, adOe, hiOut, hiOe;
	logic        memDone, addrStrobe_n, addrStrobeOe, dataStrobe_n, dataStrobeOe;
	logic        readNotWrite, readNotWriteOe, dataValidOut, readyOut;
	logic        dataValidIn = 1'b1, readyIn = 1'b1;
	int          error_cnt = 0, check_count = 0;

	always #5 clk = ~clk;

	emb_port dut (.clk, .rst_b, .romlessSelect, .regAddr, .regWdata, .regWr, .regRd, .regRdata,
		.memReq, .memWrite, .memAddr, .memWdata, .memDone, .memRdata, .addrStrobe_n, .addrStrobeOe,
		.dataStrobe_n, .dataStrobeOe, .readNotWrite, .readNotWriteOe, .adIn, .adOut, .adOe, .hiIn,
		.hiOut, .hiOe, .dataValidIn, .readyIn, .dataValidOut, .readyOut);
	emb_mem_model mem (.clk, .addrStrobe_n, .dataStrobe_n, .readNotWrite, .adOut, .hiOut, .adIn);

	task automatic check(input logic [15:0] got, input logic [15:0] exp);
		check_count++;
		if (got !== exp) begin
			error_cnt++;
			$display("wrong value at %0t: got %h expected %h", $time, got, exp);
		end
	endtask
	task automatic final_report;
		$display("checks %0d mismatches %0d", check_count, error_cnt);
		if (error_cnt == 0 && check_count > 0) $display("ALL TESTS PASSED");
		else $display("TESTS FAILED");
		$finish;
	endtask
	task automatic timeout_hit;
		error_cnt++;
		$display("timeout at %0t", $time);
		final_report();
	endtask
	task automatic do_reset(input logic romless);
		@(posedge clk);
		rst_b <= 1'b0;
		romlessSelect <= romless;
		repeat (10) @(posedge clk);
		rst_b <= 1'b1;
		repeat (2) @(posedge clk);
		#1;
	endtask
	task automatic reg_wr(input logic [3:0] a, input logic [7:0] d);
		@(posedge clk);
		regAddr <= a;
		regWdata <= d;
		regWr <= 1'b1;
		@(posedge clk);
		regWr <= 1'b0;
		#1;
	endtask
	task automatic reg_rd(input logic [3:0] a, output logic [7:0] d);
		@(posedge clk);
		regAddr <= a;
		regRd <= 1'b1;
		@(posedge clk);
		regRd <= 1'b0;
		#1 d = regRdata;
	endtask
	task automatic wait_sig(input int sel, input logic v, input int bnd);
		for (int k = 0; k < bnd; k++) begin
			@(posedge clk);
			#1;
			if ((sel == 0 ? readyOut : dataValidOut) === v) begin
				check_count++;
				return;
			end
		end
		timeout_hit();
	endtask
	// One bus transfer, watching strobes and lines cycle by cycle
	task automatic mem_xfer(input logic wr, input logic [15:0] a, input logic [7:0] wd, input int cyc,
		input logic [7:0] hm, output logic [7:0] rdat);
		int n, asLo, dsLo;
		n = 0;
		asLo = 0;
		dsLo = 0;
		@(posedge clk);
		memReq <= 1'b1;
		memWrite <= wr;
		memAddr <= a;
		memWdata <= wd;
		do begin
			@(posedge clk);
			memReq <= 1'b0;
			#1 n++;
			if (!addrStrobe_n) begin
				asLo++;
				check(hiOut & hm, a[15:8] & hm);
				check(adOut, a[7:0]);
				check(dataStrobe_n, 1'b1);
			end
			if (!dataStrobe_n) begin
				dsLo++;
				check(readNotWrite, !wr);
				if (wr) check({adOe, adOut}, {8'hff, wd});
				else check(adOe, 8'h00);
			end
			if (n > 12) timeout_hit();
		end while (memDone !== 1'b1);
		rdat = memRdata;
		check(16'(n), 16'(cyc));
		check(16'(asLo), 16'h0001);
		check(16'(dsLo), 16'(cyc - 4));
		#10 check({addrStrobe_n, dataStrobe_n}, 2'b11);
	endtask
	// ------------------------------
	// Scenarios
	// ------------------------------
	task automatic test_rom_reset;
		do_reset(1'b0);
		check(hiOe, 8'h00);
		reg_rd(`EMB_REG_MODE, rd);
		check(rd, {4'h0, `EMB_NIB_IN, `EMB_NIB_IN});
		reg_rd(4'hf, rd);
		check(rd, 8'h00);
		$display("test rom reset done");
	endtask
	task automatic test_romless;
		do_reset(1'b1);
		reg_rd(`EMB_REG_MODE, rd);
		check(rd, {4'h0, `EMB_NIB_ADDR, `EMB_NIB_ADDR});
		reg_rd(`EMB_REG_CTRL, rd);
		check(rd[`EMB_CTRL_EXT_BIT], 1'b1);
		mem_xfer(1'b1, 16'h9abc, 8'h3d, 5 + `EMB_EXT_WAIT, 8'hff, rd);
		mem_xfer(1'b0, 16'h9abc, 8'h00, 5 + `EMB_EXT_WAIT, 8'hff, rd);
		check(rd, 8'h3d);
		reg_wr(`EMB_REG_CTRL, 8'h00);
		mem_xfer(1'b1, 16'h1234, 8'hc5, 5, 8'hff, rd);
		mem_xfer(1'b0, 16'h1234, 8'h00, 5, 8'hff, rd);
		check(rd, 8'hc5);
		mem_xfer(1'b0, 16'h5a0f, 8'h00, 5, 8'hff, rd);
		check(rd, 8'h55);
		$display("test romless done");
	endtask
	task automatic test_nibble;
		reg_wr(`EMB_REG_MODE, {4'h0, `EMB_NIB_OUT, `EMB_NIB_ADDR});
		reg_wr(`EMB_REG_DOUT, 8'h5a);
		check({hiOe[7:4], hiOut[7:4]}, 8'hf5);
		mem_xfer(1'b1, 16'h3c21, 8'h77, 5, 8'h0f, rd);
		check(hiOut[7:4], 4'h5);
		mem_xfer(1'b0, 16'h3c21, 8'h00, 5, 8'h0f, rd);
		check(rd, 8'h77);
		reg_wr(`EMB_REG_MODE, {4'h0, `EMB_NIB_IN, `EMB_NIB_ADDR});
		check(hiOe[7:4], 4'h0);
		$display("test nibble done");
	endtask
	task automatic test_tristate;
		reg_wr(`EMB_REG_CTRL, 8'h02);
		check({addrStrobeOe, dataStrobeOe, readNotWriteOe, hiOe[3:0], adOe}, 15'h0000);
		@(posedge clk);
		memReq <= 1'b1;
		memWrite <= 1'b0;
		@(posedge clk);
		memReq <= 1'b0;
		repeat (10) begin
			@(posedge clk);
			#1 check(memDone, 1'b0);
		end
		reg_wr(`EMB_REG_CTRL, 8'h00);
		check({addrStrobeOe, dataStrobeOe, readNotWriteOe}, 3'b111);
		$display("test tristate done");
	endtask
	task automatic test_hs_in;
		reg_wr(`EMB_REG_MODE, 8'h00);
		reg_wr(`EMB_REG_CTRL, 8'h04);
		check(readyOut, 1'b1);
		@(posedge clk);
		hiIn <= 8'h3c;
		@(posedge clk);
		dataValidIn <= 1'b0;
		wait_sig(0, 1'b0, `EMB_DAVF_RDY_CYC + 1);
		@(posedge clk);
		hiIn <= 8'hc3;
		reg_rd(`EMB_REG_STAT, rd);
		check(rd, 8'h0a);
		reg_rd(`EMB_REG_DIN, rd);
		check(rd, 8'h3c);
		reg_rd(`EMB_REG_STAT, rd);
		check(rd, 8'h08);
		@(posedge clk);
		dataValidIn <= 1'b1;
		wait_sig(0, 1'b1, `EMB_DAVR_RDY_CYC + 1);
		$display("test handshake in done");
	endtask
	task automatic test_hs_out;
		logic [7:0] prev;
		reg_wr(`EMB_REG_MODE, {4'h0, `EMB_NIB_OUT, `EMB_NIB_OUT});
		reg_wr(`EMB_REG_DOUT, 8'ha7);
		check(dataValidOut, 1'b1);
		prev = hiOut;
		for (int k = 0; k < 10 && dataValidOut !== 1'b0; k++) begin
			prev = hiOut;
			@(posedge clk);
			#1;
		end
		check({dataValidOut, prev}, {1'b0, 8'ha7});
		@(posedge clk);
		readyIn <= 1'b0;
		wait_sig(1, 1'b1, `EMB_DAVF_RDY_CYC + 1);
		@(posedge clk);
		readyIn <= 1'b1;
		$display("test handshake out done");
	endtask

	initial begin
		test_rom_reset();
		test_romless();
		test_nibble();
		test_tristate();
		test_hs_in();
		test_hs_out();
		final_report();
	end
endmodule
